/* File: src/utx_pkg.sv */
// shared constants of the dual-channel serial transmitter
// assumes a single 250 MHz core clock and 8N1 character framing
package utx_pkg;

  // --------------------------------------------------------------
  // clock and serial timing
  // --------------------------------------------------------------
  localparam int  CLK_PERIOD_PS = 4000;
  localparam int  BAUD_BPS      = 1000000;
  localparam int  BIT_TIME_PS   = 1000000000 / BAUD_BPS * 1000;
  localparam int  BIT_CYCLES    = BIT_TIME_PS / CLK_PERIOD_PS;

  // --------------------------------------------------------------
  // storage, framing, levels
  // --------------------------------------------------------------
  localparam int         FIFO_DEPTH   = 128;
  localparam int         DATA_BITS    = 8;
  localparam logic       MARK_LEVEL   = 1'b1;
  localparam logic       SPACE_LEVEL  = 1'b0;
  localparam logic [2:0] TX_HOLD_ADDR = 3'h0;
  localparam int         PIN_SYNC_W   = 19;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_STOP
  } utx_tx_state_e;

endpackage

/* File: src/utx_sync.sv */
// two-stage synchroniser for a vector of pin levels
// assumes pins are quasi-static relative to the core clock
`timescale 1ns/1ps
module utx_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d_in;
    q_d    = meta_q;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_q <= '0;
      q_q    <= '0;
    end else begin
      meta_q <= meta_d;
      q_q    <= q_d;
    end
  end

  assign q_out = q_q;

endmodule

/* File: src/utx_chan.sv */
// one transmit channel: byte store, 8N1 shifter, space flag
// assumes writes come one per cycle from the host decode in the top
`timescale 1ns/1ps
module utx_chan #(
  parameter int DEPTH      = utx_pkg::FIFO_DEPTH,
  parameter int BIT_CYCLES = utx_pkg::BIT_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       tx_enable_in,
  input  wire logic       dma_mode1_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wr_data_in,
  output logic            serial_line_out,
  output logic            space_avail_n_out
);
  import utx_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] TICK_LOAD = CW'(BIT_CYCLES - 1);
  localparam logic [AW:0]   FULL_CNT  = (AW+1)'(DEPTH);

  logic [7:0]    mem [DEPTH];
  utx_tx_state_e state_q, state_d;
  logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic [CW-1:0] tick_q, tick_d;
  logic [2:0]    bitn_q, bitn_d;
  logic [7:0]    shf_q, shf_d;
  logic          line_q, line_d;
  logic          push, pop, full;

  // --------------------------------------------------------------
  // store and shifter
  // --------------------------------------------------------------
  assign full = (cnt_q == FULL_CNT);
  assign push = wr_in && !full;

  always_comb begin
    state_d = state_q;
    wptr_d  = wptr_q;
    rptr_d  = rptr_q;
    tick_d  = tick_q;
    bitn_d  = bitn_q;
    shf_d   = shf_q;
    line_d  = line_q;
    pop     = 1'b0;
    if (push)
      wptr_d = wptr_q + 1'b1;
    case (state_q)
      TX_IDLE: begin
        line_d = MARK_LEVEL;
        if (tx_enable_in && cnt_q != '0) begin
          pop     = 1'b1;
          shf_d   = mem[rptr_q];
          rptr_d  = rptr_q + 1'b1;
          tick_d  = TICK_LOAD;
          line_d  = SPACE_LEVEL;
          state_d = TX_START;
        end
      end
      TX_START: begin
        if (tick_q == '0) begin
          tick_d  = TICK_LOAD;
          bitn_d  = '0;
          line_d  = shf_q[0];
          state_d = TX_DATA;
        end else
          tick_d = tick_q - 1'b1;
      end
      TX_DATA: begin
        if (tick_q == '0) begin
          tick_d = TICK_LOAD;
          if (bitn_q == 3'(DATA_BITS - 1)) begin
            line_d  = MARK_LEVEL;
            state_d = TX_STOP;
          end else begin
            bitn_d = bitn_q + 1'b1;
            shf_d  = {1'b0, shf_q[7:1]};
            line_d = shf_q[1];
          end
        end else
          tick_d = tick_q - 1'b1;
      end
      TX_STOP: begin
        if (tick_q == '0)
          state_d = TX_IDLE;
        else
          tick_d = tick_q - 1'b1;
      end
      default: begin
        state_d = TX_IDLE;
        line_d  = MARK_LEVEL;
      end
    endcase
    case ({push, pop})
      2'b10:   cnt_d = cnt_q + 1'b1;
      2'b01:   cnt_d = cnt_q - 1'b1;
      default: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q <= TX_IDLE;
      wptr_q  <= '0;
      rptr_q  <= '0;
      cnt_q   <= '0;
      tick_q  <= '0;
      bitn_q  <= '0;
      shf_q   <= '0;
      line_q  <= MARK_LEVEL;
    end else begin
      state_q <= state_d;
      wptr_q  <= wptr_d;
      rptr_q  <= rptr_d;
      cnt_q   <= cnt_d;
      tick_q  <= tick_d;
      bitn_q  <= bitn_d;
      shf_q   <= shf_d;
      line_q  <= line_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push)
      mem[wptr_q] <= wr_data_in;
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign serial_line_out = line_q | ~tx_enable_in;
  // mode 1: low until full; mode 0: low only while empty
  assign space_avail_n_out = dma_mode1_in ? full
                                          : (cnt_q != '0);

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  property p_idle_mark;
    state_q == TX_IDLE && !$past(state_q == TX_IDLE) |-> serial_line_out;
  endproperty
  a_idle_mark: assert property (p_idle_mark)
    else $error("line not high after stop bit");

  property p_disabled_mark;
    !tx_enable_in |-> serial_line_out;
  endproperty
  a_disabled_mark: assert property (p_disabled_mark)
    else $error("line low while disabled");

  property p_space_low;
    cnt_q < FULL_CNT && !(dma_mode1_in == 1'b0 && cnt_q != '0)
      |-> !space_avail_n_out;
  endproperty
  a_space_low: assert property (p_space_low)
    else $error("ready high although room remains");

  property p_mode1_full;
    dma_mode1_in && wr_in && cnt_q == FULL_CNT - 1'b1 && !pop
      |=> space_avail_n_out;
  endproperty
  a_mode1_full: assert property (p_mode1_full)
    else $error("ready not high after last slot filled");

  property p_mode0_pace;
    !dma_mode1_in && cnt_q == '0 && wr_in ##1 !dma_mode1_in
      |-> space_avail_n_out;
  endproperty
  a_mode0_pace: assert property (p_mode0_pace)
    else $error("mode 0 ready stayed low after a byte");

  c_frame_start: cover property (state_q == TX_IDLE ##1 state_q == TX_START);
  c_fill_full:   cover property (full);
endmodule

/* File: src/utx_top.sv */
// dual-channel serial transmitter with selectable host strobe style
// assumes host pins are asynchronous; control levels come from core logic
//
// How it works
// - serial line high in reset, when idle and when transmitter disabled.
// - loopback forces pin high and feeds the stream to the receiver.
// - in DMA mode 1 transmit-ready is low while the channel store can take a byte.
// - in DMA mode 1 transmit-ready goes high once the store is full.
// - DMA mode 0 single transfers: ready high as soon as a byte waits.
// - raising the low-power pin enters low-power mode, no register step.
// - low-power stops the oscillator and isolates the host pins.
// - only dropping the low-power pin leaves low-power mode.
// - the falling edge of the low-power pin resets all state.
// - bus select high: separate read/write strobes, per-channel selects.
// - bus select low: one select, read/write line and data strobe.
// - master reset is active high with select high, low otherwise.
// - in single-select style the direction line high reads, low writes.
`timescale 1ns/1ps
module utx_top #(
  parameter int DEPTH      = utx_pkg::FIFO_DEPTH,
  parameter int BIT_CYCLES = utx_pkg::BIT_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       bus_select_in,
  input  wire logic       master_reset_in,
  input  wire logic       power_down_request_in,
  input  wire logic       cs_a_n_in,
  input  wire logic       cs_b_n_in,
  input  wire logic       rd_strobe_n_in,
  input  wire logic       wr_strobe_n_in,
  input  wire logic [2:0] addr_in,
  input  wire logic       addr3_in,
  input  wire logic [7:0] data_in,
  input  wire logic       tx_enable_a_in,
  input  wire logic       tx_enable_b_in,
  input  wire logic       loopback_a_in,
  input  wire logic       loopback_b_in,
  input  wire logic       dma_mode1_a_in,
  input  wire logic       dma_mode1_b_in,
  output logic            serial_out_a_out,
  output logic            serial_out_b_out,
  output logic            loop_rx_a_out,
  output logic            loop_rx_b_out,
  output logic            tx_space_avail_n_a_out,
  output logic            tx_space_avail_n_b_out,
  output logic            osc_stop_out,
  output logic            host_isolate_out
);
  import utx_pkg::*;

  // --------------------------------------------------------------
  // pin synchronisation
  // --------------------------------------------------------------
  logic [PIN_SYNC_W-1:0] pins_s;
  logic                  bus_sel_s, mr_s, pd_s;
  logic                  csa_n_s, csb_n_s, rd_n_s, wr_n_s, a3_s;
  logic [2:0]            addr_s;
  logic [7:0]            data_s;

  utx_sync #(.W(PIN_SYNC_W)) u_sync (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .d_in    ({bus_select_in, master_reset_in, power_down_request_in,
               cs_a_n_in, cs_b_n_in, rd_strobe_n_in, wr_strobe_n_in,
               addr3_in, addr_in, data_in}),
    .q_out   (pins_s)
  );

  assign {bus_sel_s, mr_s, pd_s, csa_n_s, csb_n_s, rd_n_s, wr_n_s,
          a3_s, addr_s, data_s} = pins_s;

  // --------------------------------------------------------------
  // power-down and internal reset
  // --------------------------------------------------------------
  logic pd_prev_q, pd_prev_d;
  logic pd_fall, mr_act, rst_int;

  always_comb begin
    pd_prev_d = pd_s;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in)
      pd_prev_q <= 1'b0;
    else
      pd_prev_q <= pd_prev_d;
  end

  assign pd_fall = pd_prev_q & ~pd_s;
  assign mr_act  = bus_sel_s ? mr_s : ~mr_s;
  // channels held in reset while the oscillator is stopped
  assign rst_int = srst_in | mr_act | pd_s | pd_fall;

  // level follows the pin alone, nothing else leaves this mode
  assign osc_stop_out     = pd_s;
  assign host_isolate_out = pd_s;

  // --------------------------------------------------------------
  // host write decode
  // --------------------------------------------------------------
  logic act_now, act_q, act_d, ch_b, wr_a, wr_b, wr_hit;

  always_comb begin
    if (bus_sel_s) begin
      act_now = ~wr_n_s & (~csa_n_s | ~csb_n_s);
      ch_b    = ~csb_n_s & csa_n_s;
    end else begin
      // rd pin is the direction line, wr pin the data strobe
      act_now = ~csa_n_s & ~wr_n_s & ~rd_n_s;
      ch_b    = a3_s;
    end
    act_d = act_now;
  end

  always_ff @(posedge clk_in) begin
    if (rst_int)
      act_q <= 1'b0;
    else
      act_q <= act_d;
  end

  // isolated host pins are ignored while powered down or in reset
  assign wr_hit = act_now & ~act_q & ~rst_int &
                  (addr_s == TX_HOLD_ADDR);
  assign wr_a   = wr_hit & ~ch_b;
  assign wr_b   = wr_hit & ch_b;

  // --------------------------------------------------------------
  // channels
  // --------------------------------------------------------------
  logic line_a, line_b;

  utx_chan #(.DEPTH(DEPTH), .BIT_CYCLES(BIT_CYCLES)) u_chan_a (
    .clk_in            (clk_in),
    .srst_in           (rst_int),
    .tx_enable_in      (tx_enable_a_in),
    .dma_mode1_in      (dma_mode1_a_in),
    .wr_in             (wr_a),
    .wr_data_in        (data_s),
    .serial_line_out   (line_a),
    .space_avail_n_out (tx_space_avail_n_a_out)
  );

  utx_chan #(.DEPTH(DEPTH), .BIT_CYCLES(BIT_CYCLES)) u_chan_b (
    .clk_in            (clk_in),
    .srst_in           (rst_int),
    .tx_enable_in      (tx_enable_b_in),
    .dma_mode1_in      (dma_mode1_b_in),
    .wr_in             (wr_b),
    .wr_data_in        (data_s),
    .serial_line_out   (line_b),
    .space_avail_n_out (tx_space_avail_n_b_out)
  );

  // --------------------------------------------------------------
  // loopback routing
  // --------------------------------------------------------------
  assign serial_out_a_out = loopback_a_in ? MARK_LEVEL : line_a;
  assign serial_out_b_out = loopback_b_in ? MARK_LEVEL : line_b;
  assign loop_rx_a_out    = loopback_a_in ? line_a : MARK_LEVEL;
  assign loop_rx_b_out    = loopback_b_in ? line_b : MARK_LEVEL;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  property p_loop_pin;
    loopback_a_in |-> serial_out_a_out && loop_rx_a_out == line_a;
  endproperty
  a_loop_pin: assert property (p_loop_pin)
    else $error("loopback did not isolate pin a");

  property p_pd_enter;
    power_down_request_in [*2] |=> osc_stop_out && host_isolate_out;
  endproperty
  a_pd_enter: assert property (p_pd_enter)
    else $error("low-power not entered two cycles after pin");

  property p_pd_stay;
    osc_stop_out |-> $past(power_down_request_in, 2);
  endproperty
  a_pd_stay: assert property (p_pd_stay)
    else $error("low-power held without the pin");

  property p_pd_isolate;
    osc_stop_out |-> !wr_a && !wr_b;
  endproperty
  a_pd_isolate: assert property (p_pd_isolate)
    else $error("host write taken while isolated");

  property p_pd_reset;
    $fell(pd_s) |-> rst_int ##1 !pd_s;
  endproperty
  a_pd_reset: assert property (p_pd_reset)
    else $error("no reset on low-power release");

  property p_mr_pol;
    (bus_sel_s && mr_s) || (!bus_sel_s && !mr_s) |-> rst_int;
  endproperty
  a_mr_pol: assert property (p_mr_pol)
    else $error("master reset polarity wrong");

  property p_one_chan;
    !(wr_a && wr_b);
  endproperty
  a_one_chan: assert property (p_one_chan)
    else $error("one write reached both channels");

  property p_dir_read;
    !bus_sel_s && rd_n_s |-> !wr_a && !wr_b;
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("read cycle taken as write");

  c_pd_cycle:  cover property ($rose(pd_s) ##[1:64] $fell(pd_s));
  c_sngl_wr_b: cover property (!bus_sel_s && wr_b);
  c_loop_b:    cover property (loopback_b_in && !line_b);
endmodule

/* File: tb/utx_peer.sv */
// serial peer model: 8n1 receiver decoding one transmit line
// assumes the line idles high and a bit lasts BIT_CYCLES clocks
`timescale 1ns/1ps
module utx_peer #(
  parameter int BIT_CYCLES = 4
) (
  input  wire logic       clk_in,
  input  wire logic       line_in,
  output logic      [7:0] byte_out,
  output logic            stop_out,
  output logic            valid_out
);
  logic [7:0] shift_q;

  // --------------------------------------------------------------
  // frame decoder, samples mid-bit on the falling clock edge
  // --------------------------------------------------------------
  initial begin
    valid_out = 1'b0;
    byte_out  = 8'h00;
    stop_out  = 1'b1;
    shift_q   = 8'h00;
    forever begin
      @(negedge clk_in);
      if (line_in === 1'b0) begin
        repeat (BIT_CYCLES / 2) @(negedge clk_in);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(negedge clk_in);
          shift_q[i] = line_in;
        end
        repeat (BIT_CYCLES) @(negedge clk_in);
        byte_out  <= shift_q;
        stop_out  <= line_in;
        valid_out <= 1'b1;
        @(negedge clk_in);
        valid_out <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the dual-channel serial transmitter
// assumes utx_top, utx_peer and utx_pkg are compiled before it
`timescale 1ns/1ps
module testbench;
  localparam int BITC  = 4;
  localparam int DEP   = 4;
  localparam int LIMIT = 20000;

  logic clk_in, srst_in, bus_select_in, master_reset_in;
  logic power_down_request_in, cs_a_n_in, cs_b_n_in;
  logic rd_strobe_n_in, wr_strobe_n_in, addr3_in;
  logic [2:0] addr_in;
  logic [7:0] data_in, rx_a, rx_b;
  logic tx_enable_a_in, tx_enable_b_in, loopback_a_in, loopback_b_in;
  logic dma_mode1_a_in, dma_mode1_b_in;
  logic serial_out_a_out, serial_out_b_out, loop_rx_a_out, loop_rx_b_out;
  logic tx_space_avail_n_a_out, tx_space_avail_n_b_out;
  logic osc_stop_out, host_isolate_out, line_a, line_b;
  logic stop_a, stop_b, val_a, val_b;
  logic [7:0] exp_a[$];
  logic [7:0] exp_b[$];
  logic [31:0] rng;
  int cnt_a, cnt_b, cycles, errors, samples_checked;

  utx_top #(.DEPTH(DEP), .BIT_CYCLES(BITC)) i_dut (
    .clk_in(clk_in), .srst_in(srst_in), .bus_select_in(bus_select_in),
    .master_reset_in(master_reset_in),
    .power_down_request_in(power_down_request_in),
    .cs_a_n_in(cs_a_n_in), .cs_b_n_in(cs_b_n_in),
    .rd_strobe_n_in(rd_strobe_n_in), .wr_strobe_n_in(wr_strobe_n_in),
    .addr_in(addr_in), .addr3_in(addr3_in), .data_in(data_in),
    .tx_enable_a_in(tx_enable_a_in), .tx_enable_b_in(tx_enable_b_in),
    .loopback_a_in(loopback_a_in), .loopback_b_in(loopback_b_in),
    .dma_mode1_a_in(dma_mode1_a_in), .dma_mode1_b_in(dma_mode1_b_in),
    .serial_out_a_out(serial_out_a_out), .serial_out_b_out(serial_out_b_out),
    .loop_rx_a_out(loop_rx_a_out), .loop_rx_b_out(loop_rx_b_out),
    .tx_space_avail_n_a_out(tx_space_avail_n_a_out),
    .tx_space_avail_n_b_out(tx_space_avail_n_b_out),
    .osc_stop_out(osc_stop_out), .host_isolate_out(host_isolate_out));

  assign line_a = serial_out_a_out & loop_rx_a_out;
  assign line_b = serial_out_b_out & loop_rx_b_out;
  utx_peer #(.BIT_CYCLES(BITC)) i_peer_a (.clk_in(clk_in),
    .line_in(line_a), .byte_out(rx_a), .stop_out(stop_a),
    .valid_out(val_a));
  utx_peer #(.BIT_CYCLES(BITC)) i_peer_b (.clk_in(clk_in),
    .line_in(line_b), .byte_out(rx_b), .stop_out(stop_b),
    .valid_out(val_b));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  function automatic logic exp_rdy(input int cnt, input logic m1);
    return m1 ? (cnt >= DEP) : (cnt != 0);
  endfunction

  // host write: hold four clocks, release three
  task automatic put(input logic st, input logic ch, input logic [2:0] a,
                     input logic rw);
    logic [7:0] d;
    d = rnd();
    @(posedge clk_in);
    addr_in  <= a;
    data_in  <= d;
    addr3_in <= ch;
    cs_a_n_in      <= st ? ch : 1'b0;
    cs_b_n_in      <= st ? !ch : 1'b1;
    rd_strobe_n_in <= st ? 1'b1 : rw;
    wr_strobe_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    cs_a_n_in      <= 1'b1;
    cs_b_n_in      <= 1'b1;
    rd_strobe_n_in <= 1'b1;
    wr_strobe_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    if (a == 3'h0 && !(rw && !st) && !power_down_request_in) begin
      if (!ch && cnt_a < DEP) begin
        exp_a.push_back(d);
        cnt_a++;
      end
      if (ch && cnt_b < DEP) begin
        exp_b.push_back(d);
        cnt_b++;
      end
    end
  endtask

  task automatic drain();
    for (int k = 0; k < 3000; k++) begin
      if (exp_a.size() == 0 && exp_b.size() == 0) break;
      @(posedge clk_in);
    end
    repeat (2 * BITC) @(posedge clk_in);
    cnt_a = 0;
    cnt_b = 0;
  endtask

  // --------------------------------------------------------------
  // clock, timeout and continuous checks
  // --------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (val_a === 1'b1) begin
      if (exp_a.size() == 0) chk(1'b0, "extra frame a");
      else chk(rx_a === exp_a.pop_front() && stop_a === 1'b1, "frame a");
    end
    if (val_b === 1'b1) begin
      if (exp_b.size() == 0) chk(1'b0, "extra frame b");
      else chk(rx_b === exp_b.pop_front() && stop_b === 1'b1, "frame b");
    end
    if (cycles == LIMIT) begin
      errors++;
      $display("MISMATCH %0t timeout", $time);
      print_verdict();
    end
  end

  always @(negedge clk_in) begin
    if (srst_in || !tx_enable_a_in) chk(serial_out_a_out === 1'b1, "idle a");
    if (loopback_a_in)
      chk(serial_out_a_out === 1'b1, "pin a in loop");
    else
      chk(loop_rx_a_out === 1'b1, "loop feed a");
    if (loopback_b_in) chk(serial_out_b_out === 1'b1, "pin b in loop");
    else chk(loop_rx_b_out === 1'b1, "loop feed b");
    chk(host_isolate_out === osc_stop_out, "isolate");
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {srst_in, bus_select_in, cs_a_n_in, cs_b_n_in} = 4'hf;
    {rd_strobe_n_in, wr_strobe_n_in, dma_mode1_a_in, dma_mode1_b_in} = 4'hf;
    {master_reset_in, power_down_request_in, addr3_in} = 3'h0;
    {tx_enable_a_in, tx_enable_b_in, loopback_a_in, loopback_b_in} = 4'h0;
    addr_in = 3'h0;
    data_in = 8'h00;
    rng = 32'h0001_4687;
    {cnt_a, cnt_b, cycles, errors, samples_checked} = '0;
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    chk(tx_space_avail_n_a_out === 1'b0, "ready a after reset");
    // fill a while its transmitter is off, one write past full
    for (int i = 0; i <= DEP; i++) begin
      put(1'b1, 1'b0, 3'h0, 1'b0);
      chk(tx_space_avail_n_a_out === exp_rdy(cnt_a, 1'b1), "fill a");
      chk(tx_space_avail_n_b_out === 1'b0, "b untouched");
    end
    dma_mode1_b_in <= 1'b0;
    put(1'b1, 1'b1, 3'h1, 1'b0);
    chk(tx_space_avail_n_b_out === 1'b0, "other address b");
    put(1'b1, 1'b1, 3'h0, 1'b0);
    chk(tx_space_avail_n_b_out === exp_rdy(cnt_b, 1'b0), "mode0 b");
    // send both, b looped back internally
    loopback_b_in  <= 1'b1;
    tx_enable_a_in <= 1'b1;
    tx_enable_b_in <= 1'b1;
    drain();
    chk(tx_space_avail_n_a_out === 1'b0, "a empty again");
    loopback_b_in <= 1'b0;
    // single-select style: writes to both channels and one read
    bus_select_in   <= 1'b0;
    master_reset_in <= 1'b1;
    loopback_a_in   <= 1'b1;
    repeat (8) @(posedge clk_in);
    put(1'b0, 1'b1, 3'h0, 1'b0);
    put(1'b0, 1'b0, 3'h0, 1'b0);
    put(1'b0, 1'b1, 3'h0, 1'b1);
    drain();
    // master reset clears a held byte, both polarities
    tx_enable_a_in <= 1'b0;
    dma_mode1_a_in <= 1'b0;
    loopback_a_in  <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      bus_select_in   <= s[0];
      master_reset_in <= !s[0];
      repeat (8) @(posedge clk_in);
      put(s[0], 1'b0, 3'h0, 1'b0);
      chk(tx_space_avail_n_a_out === exp_rdy(cnt_a, 1'b0), "held");
      master_reset_in <= s[0];
      repeat (4) @(posedge clk_in);
      master_reset_in <= !s[0];
      repeat (6) @(posedge clk_in);
      exp_a.delete();
      cnt_a = 0;
      chk(tx_space_avail_n_a_out === 1'b0, "master reset");
    end
    // low power: enter, refuse a write, leave with a reset
    put(1'b1, 1'b0, 3'h0, 1'b0);
    power_down_request_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(osc_stop_out === 1'b1 && host_isolate_out === 1'b1, "enter");
    put(1'b1, 1'b0, 3'h0, 1'b0);
    repeat (20) @(posedge clk_in);
    chk(osc_stop_out === 1'b1, "stays low power");
    power_down_request_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    exp_a.delete();
    cnt_a = 0;
    chk(osc_stop_out === 1'b0 && tx_space_avail_n_a_out === 1'b0, "wake");
    tx_enable_a_in <= 1'b1;
    repeat (100) @(posedge clk_in);
    chk(exp_a.size() == 0 && exp_b.size() == 0, "pending frames");
    print_verdict();
  end
endmodule
